//--- src/ipm_input_power_monitor.sv
// ipm_input_power_monitor: register file, interrupt and per-port power monitors.
// assumes: single-cycle strobes, read data valid the cycle after the read strobe.
//
// Overview of operation
// - function select 00 picks peak measurement, keeping the larger magnitude.
// - peak mode compares each sample with the store and keeps the greater.
// - every input port has its own monitor with one active function.
// - peak mode holds the largest magnitude seen in the current period.
// - function select 01 picks mean power accumulation.
// - enabling loads the 24-bit period into the timer, counting each clock.
// - mean mode adds the 15-bit magnitude shifted right nine into 24 bits.
// - at count 1 mean result moves to holding, timer reloads, store reseeds.
// - mean result is 4-bit exponent over 20-bit mantissa.
// - at count 1 an enabled interrupt fires and status updates, every mode.
// - select upper bit 1 picks threshold counting, lower bit ignored.
// - threshold mode starts at zero, counts samples above threshold.
// - threshold compared is the gain-control upper threshold register.
// - threshold period end moves count, reloads timer, clears count.
// - disable-timer bit: timer runs but count 1 makes no transfer.
// - disable-timer: holding read transfers store and reloads timer.
// - disable-timer: count 1 still raises interrupt and status.
// - clear-on-read only acts while disable-timer is set.
// - both bits: read restarts store with magnitude, or zero in threshold mode.
// - disable-timer without clear: read leaves the store running on.
`timescale 1ns/1ps
`default_nettype none
module ipm_input_power_monitor #(
  parameter int NPORTS = 4
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [31:0] regRdData,
  input wire logic [NPORTS*ipm_pkg::MAG_W-1:0] sampleMag,
  output logic [NPORTS*ipm_pkg::THR_W-1:0] upperThreshold,
  output logic interruptRequestPin
);
  localparam int MW = ipm_pkg::MAG_W;
  localparam int PW = ipm_pkg::PERIOD_W;
  localparam int TW = ipm_pkg::THR_W;
  localparam int CW = ipm_pkg::CTRL_W;

  // port blocks must fit the 8-bit address space
  if (NPORTS < 1 || NPORTS > 8) begin : g_bad
    $error("ipm_input_power_monitor: NPORTS must be 1 to 8");
  end

  logic [NPORTS-1:0] irqStatus_r;
  logic [NPORTS-1:0] irqStatus_nxt;
  logic [NPORTS-1:0] irqEnable_r;
  logic [31:0] rdData_r;
  logic [31:0] rdData_nxt;
  logic irq_r;
  logic [NPORTS-1:0] periodEnd;
  logic [NPORTS*32-1:0] portRdData;
  logic [NPORTS-1:0] portHit;
  // per port threshold registers gathered for the gain-control output
  logic [NPORTS*TW-1:0] threshBus;

  // global register decode
  wire hitStatus = (regAddr == ipm_pkg::OFF_IRQ_STATUS);
  wire hitEnable = (regAddr == ipm_pkg::OFF_IRQ_ENABLE);
  wire [7:0] portOff = regAddr - ipm_pkg::OFF_PORT_BASE;
  wire [3:0] portSel = portOff[7:4];
  wire [3:0] portReg = portOff[3:0];
  wire inPortSpace = (regAddr >= ipm_pkg::OFF_PORT_BASE);

  // per port monitors, each with its own registers
  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    logic [CW-1:0] ctrl_r;
    logic [PW-1:0] period_r;
    logic [PW-1:0] holdValue;
    logic [PW-1:0] liveValue;
    logic [31:0] rdSel;
    logic [TW-1:0] thresh_r;

    wire sel = inPortSpace && (portSel == 4'(p));
    wire wrCtrl = regWrStb && sel && (portReg == ipm_pkg::OFF_CTRL);
    wire wrPeriod = regWrStb && sel && (portReg == ipm_pkg::OFF_PERIOD);
    wire wrThresh = regWrStb && sel && (portReg == ipm_pkg::OFF_THRESH);
    wire rdHold = regRdStb && sel && (portReg == ipm_pkg::OFF_HOLD);
    wire disTimer = ctrl_r[ipm_pkg::CTRL_DIS_TIMER];

    // control, period and threshold registers of this port
    always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
        ctrl_r <= ipm_pkg::CTRL_RESET;
        period_r <= ipm_pkg::PERIOD_RESET;
        thresh_r <= ipm_pkg::THRESH_RESET;
      end else begin
        if (wrCtrl) begin
          ctrl_r <= regWrData[CW-1:0];
        end
        if (wrPeriod) begin
          period_r <= regWrData[PW-1:0];
        end
        if (wrThresh) begin
          thresh_r <= regWrData[TW-1:0];
        end
      end
    end

    ipm_port_core #(
      .MAG_W(MW),
      .PERIOD_W(PW),
      .THR_W(TW)
    ) u_core (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .enable(ctrl_r[ipm_pkg::CTRL_ENABLE]),
      .funcSel(ctrl_r[ipm_pkg::CTRL_FUNC_LO +: 2]),
      .disTimer(disTimer),
      .clrOnRead(ctrl_r[ipm_pkg::CTRL_CLR_ON_READ]),
      .period(period_r),
      .threshold(thresh_r),
      .sampleMag(sampleMag[p*MW +: MW]),
      .holdRead(rdHold),
      .periodEnd(periodEnd[p]),
      .holdValue(holdValue),
      .liveValue(liveValue)
    );

    // read returns the value being transferred when read-driven
    always_comb begin
      rdSel = ipm_pkg::DATA_ZERO;
      case (portReg)
        ipm_pkg::OFF_CTRL: rdSel = 32'(ctrl_r);
        ipm_pkg::OFF_PERIOD: rdSel = 32'(period_r);
        ipm_pkg::OFF_THRESH: rdSel = 32'(thresh_r);
        ipm_pkg::OFF_HOLD: rdSel = disTimer ? 32'(liveValue) : 32'(holdValue);
        default: rdSel = ipm_pkg::DATA_ZERO;
      endcase
    end
    assign portHit[p] = sel;
    assign threshBus[p*TW +: TW] = thresh_r;
    assign portRdData[p*32 +: 32] = rdSel;
  end

  // read data mux, unmapped addresses read zero
  always_comb begin
    rdData_nxt = ipm_pkg::DATA_ZERO;
    if (regRdStb) begin
      if (hitStatus) begin
        rdData_nxt = 32'(irqStatus_r);
      end else if (hitEnable) begin
        rdData_nxt = 32'(irqEnable_r);
      end else begin
        for (int i = 0; i < NPORTS; i++) begin
          if (portHit[i]) begin
            rdData_nxt = portRdData[i*32 +: 32];
          end
        end
      end
    end
  end

  // sticky status, set wins over write-one-to-clear
  assign irqStatus_nxt = (irqStatus_r & ~((regWrStb && hitStatus) ? regWrData[NPORTS-1:0] : '0))
    | periodEnd;

  // interrupt status, enable, pin and read data registers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irqStatus_r <= '0;
      irqEnable_r <= '0;
      irq_r <= 1'b0;
      rdData_r <= ipm_pkg::DATA_ZERO;
    end else begin
      irqStatus_r <= irqStatus_nxt;
      if (regWrStb && hitEnable) begin
        irqEnable_r <= regWrData[NPORTS-1:0];
      end
      irq_r <= |(irqStatus_nxt & irqEnable_r);
      rdData_r <= rdData_nxt;
    end
  end

  assign regRdData = rdData_r;
  assign interruptRequestPin = irq_r;
  assign upperThreshold = threshBus;

endmodule // ipm_input_power_monitor
`default_nettype wire

//--- src/ipm_pkg.sv
// ipm_pkg: shared constants of the input power monitor.
// assumes: a plain strobe register port with 8-bit byte addresses and 32-bit data.
package ipm_pkg;

  // measurement function select codes (upper bit set means threshold counting)
  localparam logic [1:0] FUNC_PEAK = 2'h0;
  localparam logic [1:0] FUNC_MEAN = 2'h1;

  // widths of the datapath
  localparam int MAG_W = 15;
  localparam int PERIOD_W = 24;
  localparam int THR_W = 10;
  localparam int MEAN_SHIFT = 9;
  localparam int EXP_W = 4;
  localparam int MANT_W = 20;

  // global register offsets
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h00;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'h04;
  // per port block: base plus port index times stride
  localparam logic [7:0] OFF_PORT_BASE = 8'h10;
  localparam logic [7:0] PORT_STRIDE = 8'h10;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_PERIOD = 4'h4;
  localparam logic [3:0] OFF_THRESH = 4'h8;
  localparam logic [3:0] OFF_HOLD = 4'hC;

  // monitor control field positions
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_FUNC_LO = 1;
  localparam int CTRL_DIS_TIMER = 3;
  localparam int CTRL_CLR_ON_READ = 4;
  localparam int CTRL_W = 5;

  // values after reset
  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
  localparam logic [PERIOD_W-1:0] PERIOD_RESET = 24'h000000;
  localparam logic [THR_W-1:0] THRESH_RESET = 10'h000;
  localparam logic [31:0] DATA_ZERO = 32'h00000000;

  // timer value that ends a period
  localparam logic [PERIOD_W-1:0] TIMER_END = 24'h000001;

endpackage : ipm_pkg

//--- src/ipm_port_core.sv
// ipm_port_core: power monitor of one input port (peak, mean, threshold count).
// assumes: one magnitude per sys_clk; control and period come from registers.
`timescale 1ns/1ps
`default_nettype none
module ipm_port_core #(
  parameter int MAG_W = ipm_pkg::MAG_W,
  parameter int PERIOD_W = ipm_pkg::PERIOD_W,
  parameter int THR_W = ipm_pkg::THR_W
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic [1:0] funcSel,
  input wire logic disTimer,
  input wire logic clrOnRead,
  input wire logic [PERIOD_W-1:0] period,
  input wire logic [THR_W-1:0] threshold,
  input wire logic [MAG_W-1:0] sampleMag,
  input wire logic holdRead,
  output logic periodEnd,
  output logic [PERIOD_W-1:0] holdValue,
  output logic [PERIOD_W-1:0] liveValue
);
  // elaboration check of the widths the datapath relies on
  if (MAG_W <= ipm_pkg::MEAN_SHIFT || MAG_W < THR_W || PERIOD_W != 24) begin : g_bad
    $error("ipm_port_core: unsupported width parameters");
  end

  logic active_r;
  logic [1:0] modeKey_r;
  logic [PERIOD_W-1:0] timer_r;
  logic [PERIOD_W-1:0] msr_r;
  logic [PERIOD_W-1:0] hold_r;

  // mean result as float: 4-bit exponent above a 20-bit mantissa
  function automatic logic [PERIOD_W-1:0] fmtFloat(input logic [PERIOD_W-1:0] acc);
    logic [4:0] lz;
    logic [PERIOD_W-1:0] norm;
    lz = 5'd14;
    for (int i = 0; i < 14; i++) begin
      if (acc[PERIOD_W-1-i] && lz == 5'd14) begin
        lz = 5'(i);
      end
    end
    norm = acc << lz;
    fmtFloat = {4'(lz + 5'd1), norm[PERIOD_W-1 -: ipm_pkg::MANT_W]};
  endfunction

  wire thrMode = funcSel[1];
  wire [1:0] modeKey = thrMode ? 2'h2 : funcSel;
  wire meanMode = !thrMode && (funcSel[0] == ipm_pkg::FUNC_MEAN[0]);
  wire restart = enable && (!active_r || modeKey != modeKey_r);
  wire [PERIOD_W-1:0] magExt = PERIOD_W'(sampleMag);
  wire crossing = sampleMag[MAG_W-1 -: THR_W] > threshold;
  wire [PERIOD_W-1:0] seed = thrMode ? '0 : magExt;
  wire [PERIOD_W-1:0] peakStep = (magExt > msr_r) ? magExt : msr_r;
  // mean adds the magnitude shifted right by nine
  wire [PERIOD_W-1:0] meanStep = msr_r + PERIOD_W'(sampleMag[MAG_W-1:ipm_pkg::MEAN_SHIFT]);
  wire [PERIOD_W-1:0] thrStep = msr_r + PERIOD_W'(crossing);
  wire [PERIOD_W-1:0] msrStep = thrMode ? thrStep : (meanMode ? meanStep : peakStep);
  // period end at a count of 1
  wire tc = active_r && !restart && (timer_r == ipm_pkg::TIMER_END);
  wire rdXfer = active_r && !restart && disTimer && holdRead;

  assign liveValue = meanMode ? fmtFloat(msr_r) : msr_r;
  assign holdValue = hold_r;
  assign periodEnd = tc;

  // period timer, working store and holding register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      active_r <= 1'b0;
      modeKey_r <= 2'h0;
      timer_r <= ipm_pkg::PERIOD_RESET;
      msr_r <= '0;
      hold_r <= '0;
    end else if (!enable) begin
      active_r <= 1'b0;
    end else if (restart) begin
      active_r <= 1'b1;
      modeKey_r <= modeKey;
      timer_r <= period;
      msr_r <= seed;
    end else if (rdXfer) begin
      hold_r <= liveValue;
      timer_r <= period;
      msr_r <= clrOnRead ? seed : msrStep;
    end else if (tc && !disTimer) begin
      hold_r <= liveValue;
      timer_r <= period;
      msr_r <= seed;
    end else begin
      timer_r <= tc ? period : timer_r - PERIOD_W'(1);
      msr_r <= msrStep;
    end
  end

endmodule // ipm_port_core
`default_nettype wire

//--- tb/ipm_monitor_chk.sv
// ipm_monitor_chk: port-level assertions of the power monitor.
// assumes: bound to ipm_input_power_monitor, port 0 registers at 0x10.
`timescale 1ns/1ps
`default_nettype none
module ipm_monitor_chk #(
  parameter int NPORTS = 4
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic [31:0] regRdData,
  input wire logic [NPORTS*ipm_pkg::MAG_W-1:0] sampleMag,
  input wire logic [NPORTS*ipm_pkg::THR_W-1:0] upperThreshold,
  input wire logic interruptRequestPin
);
  logic [NPORTS-1:0] irqEn_r;
  // shadow of the interrupt enable register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) irqEn_r <= '0;
    else if (regWrStb && regAddr == 8'h04) irqEn_r <= regWrData[NPORTS-1:0];
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  AST_RD_IDLE: assert property (!$past(regRdStb) |-> regRdData == 32'h00000000)
    else $error("read data not zero outside a read");
  AST_THR_OUT: assert property (regWrStb && regAddr == 8'h18 |=>
    upperThreshold[9:0] == $past(regWrData[9:0])) else $error("threshold output not updated");
  AST_THR_HOLD: assert property (!regWrStb |=> $stable(upperThreshold))
    else $error("threshold output moved without a write");
  AST_THR_RD: assert property (regRdStb && regAddr == 8'h18 |=>
    regRdData == {22'h000000, $past(upperThreshold[9:0])}) else $error("threshold read wrong");
  AST_CTRL_RB: assert property (regWrStb && regAddr == 8'h10 ##2 regRdStb && regAddr == 8'h10
    |=> regRdData[4:0] == $past(regWrData[4:0], 3)) else $error("control readback wrong");
  AST_PER_RB: assert property (regWrStb && regAddr == 8'h14 ##2 regRdStb && regAddr == 8'h14
    |=> regRdData[23:0] == $past(regWrData[23:0], 3)) else $error("period readback wrong");
  AST_HOLD_W: assert property (regRdStb && regAddr == 8'h1C |=> regRdData[31:24] == 8'h00)
    else $error("holding word wider than 24 bits");
  AST_IRQ_MASK: assert property (irqEn_r == '0 |=> !interruptRequestPin)
    else $error("interrupt pin high while masked");
  AST_IRQ_EN: assert property ($rose(interruptRequestPin) |-> $past(irqEn_r) != '0)
    else $error("interrupt rose without enable");
  AST_IRQ_CLR: assert property (regWrStb && regAddr == 8'h00 && regWrData[NPORTS-1:0] == '1
    |-> ##2 !interruptRequestPin) else $error("interrupt not cleared");
endmodule // ipm_monitor_chk
bind ipm_input_power_monitor ipm_monitor_chk #(.NPORTS(NPORTS)) u_chk (.sys_clk, .resetn,
  .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData, .sampleMag, .upperThreshold,
  .interruptRequestPin);
`default_nettype wire

//--- tb/ipm_host_model.sv
// ipm_host_model: host side of the register port, one access at a time.
// assumes: tasks are called from a process running on sys_clk edges.
`timescale 1ns/1ps
`default_nettype none
module ipm_host_model (
  input wire logic sys_clk,
  output logic [7:0] regAddr,
  output logic [31:0] regWrData,
  output logic regWrStb,
  output logic regRdStb,
  input wire logic [31:0] regRdData
);
  // bus idle at time zero
  initial begin
    regAddr = 8'h00;
    regWrData = 32'h00000000;
    regWrStb = 1'b0;
    regRdStb = 1'b0;
  end
  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge sys_clk);
    regWrStb <= 1'b0;
  endtask
  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    @(posedge sys_clk);
    d = regRdData;
  endtask
endmodule // ipm_host_model
`default_nettype wire

//--- tb/tb_top.sv
// tb_top: self-checking bench of the input power monitor, port 0 exercised.
// assumes: host model drives the register port; samples driven here.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int NP = 2;
  logic sys_clk;
  logic resetn;
  logic [7:0] regAddr;
  logic [31:0] regWrData;
  logic regWrStb;
  logic regRdStb;
  logic [31:0] regRdData;
  logic [NP*15-1:0] sampleMag;
  logic [NP*10-1:0] upperThreshold;
  logic interruptRequestPin;
  logic [14:0] level;
  logic noiseOn;
  logic [31:0] seed = 32'h00000018;
  logic [31:0] h;
  logic [7:0] addrs [7] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h18, 8'h1C, 8'hF0};
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  int s;
  int t;
  ipm_input_power_monitor #(.NPORTS(NP)) u_ipm_input_power_monitor (.sys_clk, .resetn,
    .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData, .sampleMag, .upperThreshold,
    .interruptRequestPin);
  ipm_host_model u_ipm_host_model (.sys_clk, .regAddr, .regWrData, .regWrStb, .regRdStb,
    .regRdData);
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  function automatic logic [14:0] rnd15();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[14:0];
  endfunction
  // port 0 gets small noise or a set level, port 1 random samples
  always @(posedge sys_clk) begin
    sampleMag[14:0] <= noiseOn ? (rnd15() & 15'h00FF) : level;
    sampleMag[29:15] <= rnd15();
  end
  // hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_ipm_host_model.wr(a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    u_ipm_host_model.rd(a, h);
  endtask
  // one large sample amid the noise
  task automatic spike(input logic [14:0] v);
    @(posedge sys_clk);
    noiseOn <= 1'b0;
    level <= v;
    @(posedge sys_clk);
    noiseOn <= 1'b1;
  endtask
  // wait for a period end on the pin, then clear status
  task automatic waitPe();
    int n;
    n = 0;
    repeat (2) @(posedge sys_clk);
    while (interruptRequestPin !== 1'b1 && n < 5000) begin
      @(posedge sys_clk);
      n++;
    end
    check("irqPin", 32'h1, interruptRequestPin);
    wr(8'h00, 32'hFFFFFFFF);
  endtask
  // mean result: exponent from leading zeros, mantissa normalised
  function automatic logic [31:0] fmt(input int acc);
    int lz;
    int e;
    lz = 0;
    while (lz < 24 && acc[23-lz] == 1'b0) lz++;
    e = (lz + 1 > 15) ? 15 : lz + 1;
    return (e << 20) | (((acc << (e - 1)) >> 4) & 32'h000FFFFF);
  endfunction
  initial begin
    resetn = 1'b0;
    level = 15'h0000;
    noiseOn = 1'b1;
    sampleMag = '0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    wr(8'hF0, 32'hFFFFFFFF);
    foreach (addrs[i]) begin
      rd(addrs[i]);
      check("resetRead", 32'h0, h);
    end
    wr(8'h04, 32'h00000001);
    wr(8'h14, 32'h00000028);
    rd(8'h14);
    check("period", 32'h28, h);
    wr(8'h10, 32'h00000001);
    rd(8'h10);
    check("ctrl", 32'h1, h);
    s = 32'h4000 | rnd15();
    spike(s[14:0]);
    waitPe();
    rd(8'h1C);
    check("peakHold", s, h);
    waitPe();
    rd(8'h1C);
    check("peakReseed", 32'h1, h < 32'h100);
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h00000BB8);
    s = rnd15();
    level <= s[14:0];
    noiseOn <= 1'b0;
    wr(8'h10, 32'h00000003);
    waitPe();
    waitPe();
    rd(8'h1C);
    // the period's first sample seeds the store whole, the other 2999 enter shifted
    check("meanHold", fmt(s + 2999 * (s >> 9)), h);
    for (int f = 2; f < 4; f++) begin
      t = rnd15() & 32'h3FE;
      wr(8'h10, 32'h0);
      wr(8'h18, t);
      wr(8'h14, 32'h14);
      @(negedge sys_clk);
      check("thrOut", t, upperThreshold[9:0]);
      level <= (f == 2) ? ((t + 1) << 5) : ((t << 5) | 5'h1F);
      wr(8'h10, (f << 1) | 1);
      waitPe();
      waitPe();
      rd(8'h1C);
      check("thrCount", (f == 2) ? 19 : 0, h);
    end
    noiseOn <= 1'b1;
    for (int c = 0; c < 2; c++) begin
      wr(8'h10, 32'h0);
      wr(8'h14, 32'h1E);
      wr(8'h10, 32'h9 | (c << 4));
      s = 32'h4000 | rnd15();
      spike(s[14:0]);
      rd(8'h1C);
      check("disRead", s, h);
      waitPe();
      rd(8'h1C);
      if (c == 1) check("clrRestart", 32'h1, h < 32'h100);
      else check("keepStore", s, h);
    end
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
